// ### src/mgmt_regs.svh
`ifndef MGMT_REGS_SVH
`define MGMT_REGS_SVH
// ==========================================================================
// Register offsets and field positions.
`define OFS_STATUS 8'h02
`define OFS_LOS 8'h03
`define OFS_FAULT 8'h04
`define OFS_LOL 8'h05
`define OFS_POWER 8'h5D
`define OFS_CDR 8'h62
`define OFS_MASK_LOS 8'h64
`define OFS_MASK_FAULT 8'h65
`define OFS_MASK_LOL 8'h66
`define OFS_PAGE 8'h7F
`define OFS_EQ 8'hEA
`define OFS_EMPH 8'hEC
`define OFS_AMP 8'hEE
`define UPPER_PAGE 8'h03
`define BIT_NOT_READY 0
`define BIT_PDOWN 1
// ==========================================================================
// Reset values and code limits.
`define RST_BYTE 8'h00
`define RST_CODE 16'h0000
`define SYNC_RST 21'h1B0000
`define CODE_MAX_EQ 4'hA
`define CODE_MAX_EMPH 4'h7
`define CODE_MAX_AMP 4'h3
`define DEV_ADDR 7'h50
// ==========================================================================
// Timing.
`define CLK_HZ 10000000
`define CLK_PERIOD_NS 100
`define T_INIT_MS 2000
`define T_RESET_INIT_NS 2000
`define T_RESET_PULSE_NS 500
`define RESET_PULSE_CYC ((`T_RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_INIT_CYC (`T_RESET_INIT_NS / `CLK_PERIOD_NS)
`define INIT_CYC (`T_INIT_MS * (`CLK_HZ / 1000))
`endif

// ### src/mgmt_pkg.sv
package mgmt_pkg;
  typedef enum logic [3:0] {
    TW_IDLE = 4'h0,
    TW_DEV = 4'h1,
    TW_DEV_ACK = 4'h2,
    TW_ADDR = 4'h3,
    TW_ADDR_ACK = 4'h4,
    TW_WR = 4'h5,
    TW_WR_ACK = 4'h6,
    TW_RD = 4'h7,
    TW_RD_ACK = 4'h8
  } tw_state_t;
endpackage

// ### src/two_wire_target.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_target #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Bus lines, already synchronised.
  input wire logic enable,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic sda_oe,
  // Register access.
  output logic [7:0] reg_addr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb,
  input wire logic [7:0] rd_data
);
  mgmt_pkg::tw_state_t state_ff;
  logic scl_q_ff;
  logic sda_q_ff;
  logic [7:0] shift_ff;
  logic [3:0] cnt_ff;
  logic is_read_ff;
  logic nack_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic full;

  assign scl_rise = scl_s & ~scl_q_ff;
  assign scl_fall = ~scl_s & scl_q_ff;
  assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign full = (cnt_ff == 4'h8);

  always_ff @(posedge clk_sys) begin
    scl_q_ff <= rst ? 1'b1 : scl_s;
    sda_q_ff <= rst ? 1'b1 : sda_s;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    if (rst) begin
      state_ff <= mgmt_pkg::TW_IDLE;
      sda_oe <= 1'b0;
      shift_ff <= 8'h00;
      cnt_ff <= 4'h0;
      is_read_ff <= 1'b0;
      nack_ff <= 1'b0;
      reg_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (!enable || stop_det) begin
      state_ff <= mgmt_pkg::TW_IDLE;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state_ff <= mgmt_pkg::TW_DEV;
      sda_oe <= 1'b0;
      cnt_ff <= 4'h0;
    end else if (scl_rise) begin
      cnt_ff <= cnt_ff + 4'h1;
      if (state_ff == mgmt_pkg::TW_RD_ACK) begin
        nack_ff <= sda_s;
      end else if (state_ff != mgmt_pkg::TW_RD) begin
        shift_ff <= {shift_ff[6:0], sda_s};
      end
    end else if (scl_fall) begin
      unique case (state_ff)
        mgmt_pkg::TW_DEV: begin
          if (full) begin
            cnt_ff <= 4'h0;
            is_read_ff <= shift_ff[0];
            sda_oe <= (shift_ff[7:1] == DEV_ADDR);
            state_ff <= (shift_ff[7:1] == DEV_ADDR) ? mgmt_pkg::TW_DEV_ACK : mgmt_pkg::TW_IDLE;
          end
        end
        mgmt_pkg::TW_DEV_ACK, mgmt_pkg::TW_RD_ACK: begin
          cnt_ff <= 4'h0;
          if (state_ff == mgmt_pkg::TW_RD_ACK && nack_ff) begin
            state_ff <= mgmt_pkg::TW_IDLE;
            sda_oe <= 1'b0;
          end else if (is_read_ff) begin
            state_ff <= mgmt_pkg::TW_RD;
            shift_ff <= rd_data;
            rd_stb <= 1'b1;
            sda_oe <= ~rd_data[7];
          end else begin
            state_ff <= mgmt_pkg::TW_ADDR;
            sda_oe <= 1'b0;
          end
        end
        mgmt_pkg::TW_ADDR, mgmt_pkg::TW_WR: begin
          if (full) begin
            cnt_ff <= 4'h0;
            sda_oe <= 1'b1;
            if (state_ff == mgmt_pkg::TW_ADDR) begin
              reg_addr <= shift_ff;
              state_ff <= mgmt_pkg::TW_ADDR_ACK;
            end else begin
              wr_data <= shift_ff;
              wr_stb <= 1'b1;
              state_ff <= mgmt_pkg::TW_WR_ACK;
            end
          end
        end
        mgmt_pkg::TW_ADDR_ACK, mgmt_pkg::TW_WR_ACK: begin
          cnt_ff <= 4'h0;
          sda_oe <= 1'b0;
          state_ff <= mgmt_pkg::TW_WR;
          if (state_ff == mgmt_pkg::TW_WR_ACK) begin
            reg_addr <= reg_addr + 8'h01;
          end
        end
        mgmt_pkg::TW_RD: begin
          if (full) begin
            cnt_ff <= 4'h0;
            sda_oe <= 1'b0;
            reg_addr <= reg_addr + 8'h01;
            state_ff <= mgmt_pkg::TW_RD_ACK;
          end else begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            sda_oe <= ~shift_ff[6];
          end
        end
        mgmt_pkg::TW_IDLE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state_ff <= mgmt_pkg::TW_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### src/transceiver_mgmt_ctrl_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_regs.svh"
// Notes on behaviour
// - Latched transmit loss-of-lock for lanes 4..1 sit in bits 7..4 of byte 5.
// - Latched receive loss-of-lock for lanes 4..1 sit in bits 3..0 of byte 5.
// - Byte 98 bits 7..4 turn transmit retimers of lanes 4..1 on when 1.
// - Byte 98 bits 3..0 turn receive retimers of lanes 4..1 on when 1.
// - Amplitude codes 0 to 3 pick the four swing ranges; higher codes are reserved.
// - Equalization code gives boost in dB, 0 to 10; higher codes reserved.
// - Emphasis code gives dB, 0 to 7; codes with top bit set reserved.
// - After any reset the module becomes fully functional within 2000 ms.
// - A reset pin low past the minimum pulse starts reset within 2 us.
// - Within 2000 ms the not-ready bit clears and the interrupt asserts.
// - Low-power request lowers power within 100 us.
// - Interrupt pin goes low within 200 ms of any interrupt condition.
// - Interrupt pin releases within 500 us after its flag is read clear.
// - Receive loss of signal sets its flag and interrupt within 100 ms.
// - Transmit fault sets its flag and interrupt within 200 ms.
// - Any other flag condition sets its flag and interrupt within 200 ms.
// - A set mask blocks its source within 100 ms; clearing resumes it.
// - Bus answers within 100 us of select low and stops after release.
// - Power-down bit lowers power within 100 ms; clearing restores within 300 ms.
// - Full function is shown by the interrupt once not-ready has cleared.
module transceiver_mgmt_ctrl_status #(
  parameter logic [31:0] INIT_CYCLES = `INIT_CYC,
  parameter int unsigned LANES = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Module pins.
  input wire logic reset_in_n,
  input wire logic module_select_n,
  input wire logic low_power_request,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq_out_n,
  // Lane status.
  input wire logic [LANES-1:0] tx_lock_lost,
  input wire logic [LANES-1:0] rx_lock_lost,
  input wire logic [LANES-1:0] rx_signal_lost,
  input wire logic [LANES-1:0] tx_fault,
  // Lane controls.
  output logic [LANES-1:0] tx_retimer_on,
  output logic [LANES-1:0] rx_retimer_on,
  output logic [15:0] tx_eq_code,
  output logic [15:0] rx_emph_code,
  output logic [15:0] rx_amp_code,
  // Module state.
  output logic low_power_active,
  output logic core_reset,
  output logic data_not_ready
);
  // ==========================================================================
  // Pin synchronisers.
  logic [20:0] sync1_ff;
  logic [20:0] sync2_ff;
  logic rst_n_s;
  logic sel_n_s;
  logic lp_s;
  logic [3:0] tx_lol_s;
  logic [3:0] rx_lol_s;
  logic [3:0] rx_los_s;
  logic [3:0] tx_fault_s;

  always_ff @(posedge clk_sys) begin
    sync1_ff <= rst ? `SYNC_RST : {reset_in_n, module_select_n, low_power_request, scl_in, sda_in,
                                   tx_lock_lost, rx_lock_lost, rx_signal_lost, tx_fault};
    sync2_ff <= rst ? `SYNC_RST : sync1_ff;
  end

  assign rst_n_s = sync2_ff[20];
  assign sel_n_s = sync2_ff[19];
  assign lp_s = sync2_ff[18];
  assign tx_lol_s = sync2_ff[15:12];
  assign rx_lol_s = sync2_ff[11:8];
  assign rx_los_s = sync2_ff[7:4];
  assign tx_fault_s = sync2_ff[3:0];

  // ==========================================================================
  // Reset pin filter and initialization timer.
  logic [4:0] low_cnt_ff;
  logic [31:0] init_cnt_ff;
  logic clr_all;
  logic init_done;

  assign clr_all = rst | core_reset;
  assign init_done = (init_cnt_ff == 32'h00000001) & ~clr_all;

  always_ff @(posedge clk_sys) begin
    if (rst || rst_n_s) begin
      low_cnt_ff <= 5'h00;
    end else if (low_cnt_ff != 5'(`RESET_PULSE_CYC)) begin
      low_cnt_ff <= low_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    core_reset <= ~rst & ~rst_n_s & (low_cnt_ff >= 5'(`RESET_PULSE_CYC - 1));
  end

  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      init_cnt_ff <= INIT_CYCLES;
      data_not_ready <= 1'b1;
    end else begin
      init_cnt_ff <= (init_cnt_ff != 32'h00000000) ? init_cnt_ff - 32'h00000001 : init_cnt_ff;
      data_not_ready <= data_not_ready & ~init_done;
    end
  end

  // ==========================================================================
  // Two-wire access.
  logic [7:0] reg_addr;
  logic wr_stb;
  logic [7:0] wr_data;
  logic rd_stb;
  logic [7:0] rd_mux;
  logic [7:0] rd_snap_ff;
  logic [7:0] page_ff;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs, input logic [7:0] page);
    reg_hit = (addr == ofs) && (!ofs[7] || page == `UPPER_PAGE);
  endfunction

  two_wire_target #(
    .DEV_ADDR(`DEV_ADDR)
  ) u_target (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(~sel_n_s),
    .scl_s(sync2_ff[17]),
    .sda_s(sync2_ff[16]),
    .sda_oe(sda_oe),
    .reg_addr(reg_addr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_stb(rd_stb),
    .rd_data(rd_mux)
  );

  assign sda_out = 1'b0;

  // ==========================================================================
  // Control registers.
  logic [7:0] cdr_ff;
  logic [7:0] power_ff;
  logic [7:0] mask_los_ff;
  logic [7:0] mask_fault_ff;
  logic [7:0] mask_lol_ff;
  logic [15:0] eq_ff;
  logic [15:0] emph_ff;
  logic [15:0] amp_ff;
  wire [15:0] nxt_eq;
  wire [15:0] nxt_emph;
  wire [15:0] nxt_amp;
  logic wr_cdr;
  logic wr_power;
  logic wr_page;
  logic wr_mlos;
  logic wr_mfault;
  logic wr_mlol;

  assign wr_cdr = wr_stb & reg_hit(reg_addr, `OFS_CDR, page_ff);
  assign wr_power = wr_stb & reg_hit(reg_addr, `OFS_POWER, page_ff);
  assign wr_page = wr_stb & reg_hit(reg_addr, `OFS_PAGE, page_ff);
  assign wr_mlos = wr_stb & reg_hit(reg_addr, `OFS_MASK_LOS, page_ff);
  assign wr_mfault = wr_stb & reg_hit(reg_addr, `OFS_MASK_FAULT, page_ff);
  assign wr_mlol = wr_stb & reg_hit(reg_addr, `OFS_MASK_LOL, page_ff);

  always_ff @(posedge clk_sys) begin
    cdr_ff <= clr_all ? `RST_BYTE : (wr_cdr ? wr_data : cdr_ff);
    power_ff <= clr_all ? `RST_BYTE : (wr_power ? wr_data : power_ff);
    page_ff <= clr_all ? `RST_BYTE : (wr_page ? wr_data : page_ff);
    mask_los_ff <= clr_all ? `RST_BYTE : (wr_mlos ? wr_data : mask_los_ff);
    mask_fault_ff <= clr_all ? `RST_BYTE : (wr_mfault ? wr_data : mask_fault_ff);
    mask_lol_ff <= clr_all ? `RST_BYTE : (wr_mlol ? wr_data : mask_lol_ff);
    eq_ff <= clr_all ? `RST_CODE : nxt_eq;
    emph_ff <= clr_all ? `RST_CODE : nxt_emph;
    amp_ff <= clr_all ? `RST_CODE : nxt_amp;
  end

  // Each lane owns one nibble; a reserved code leaves the nibble unchanged.
  for (genvar k = 0; k < 4; k++) begin : g_lane
    localparam logic [7:0] BYTE_SEL = 8'(k / 2);
    wire [3:0] wnib = (k % 2 == 0) ? wr_data[7:4] : wr_data[3:0];
    wire hit_eq = wr_stb & reg_hit(reg_addr, `OFS_EQ + BYTE_SEL, page_ff);
    wire hit_emph = wr_stb & reg_hit(reg_addr, `OFS_EMPH + BYTE_SEL, page_ff);
    wire hit_amp = wr_stb & reg_hit(reg_addr, `OFS_AMP + BYTE_SEL, page_ff);
    assign nxt_eq[15-4*k -: 4] = (hit_eq && wnib <= `CODE_MAX_EQ) ? wnib : eq_ff[15-4*k -: 4];
    assign nxt_emph[15-4*k -: 4] = (hit_emph && wnib <= `CODE_MAX_EMPH) ? wnib : emph_ff[15-4*k -: 4];
    assign nxt_amp[15-4*k -: 4] = (hit_amp && wnib <= `CODE_MAX_AMP) ? wnib : amp_ff[15-4*k -: 4];
  end

  assign tx_retimer_on = cdr_ff[7:4];
  assign rx_retimer_on = cdr_ff[3:0];
  assign tx_eq_code = eq_ff;
  assign rx_emph_code = emph_ff;
  assign rx_amp_code = amp_ff;

  always_ff @(posedge clk_sys) begin
    low_power_active <= ~clr_all & (lp_s | power_ff[`BIT_PDOWN]);
  end

  // ==========================================================================
  // Latched flags, cleared by reading them.
  logic [7:0] lol_ff;
  logic [3:0] los_ff;
  logic [3:0] fault_ff;
  logic ready_flag_ff;
  logic rd_lol;
  logic rd_los;
  logic rd_fault;
  logic rd_status;
  logic irq_cond;

  assign rd_lol = rd_stb & reg_hit(reg_addr, `OFS_LOL, page_ff);
  assign rd_los = rd_stb & reg_hit(reg_addr, `OFS_LOS, page_ff);
  assign rd_fault = rd_stb & reg_hit(reg_addr, `OFS_FAULT, page_ff);
  assign rd_status = rd_stb & reg_hit(reg_addr, `OFS_STATUS, page_ff);

  always_ff @(posedge clk_sys) begin
    rd_snap_ff <= rst ? 8'h00 : rd_mux;
    lol_ff <= clr_all ? 8'h00 : ((lol_ff & ~(rd_lol ? rd_snap_ff : 8'h00)) | {tx_lol_s, rx_lol_s});
    los_ff <= clr_all ? 4'h0 : ((los_ff & ~(rd_los ? rd_snap_ff[3:0] : 4'h0)) | rx_los_s);
    fault_ff <= clr_all ? 4'h0 : ((fault_ff & ~(rd_fault ? rd_snap_ff[3:0] : 4'h0)) | tx_fault_s);
    ready_flag_ff <= clr_all ? 1'b0 : ((ready_flag_ff & ~rd_status) | init_done);
  end

  assign irq_cond = (|(lol_ff & ~mask_lol_ff)) | (|(los_ff & ~mask_los_ff[3:0])) |
                    (|(fault_ff & ~mask_fault_ff[3:0])) | ready_flag_ff;

  always_ff @(posedge clk_sys) begin
    irq_out_n <= rst ? 1'b1 : ~irq_cond;
  end

  // ==========================================================================
  // Read selection.
  assign rd_mux = reg_hit(reg_addr, `OFS_STATUS, page_ff) ? {7'h00, data_not_ready} :
                  reg_hit(reg_addr, `OFS_LOS, page_ff) ? {4'h0, los_ff} :
                  reg_hit(reg_addr, `OFS_FAULT, page_ff) ? {4'h0, fault_ff} :
                  reg_hit(reg_addr, `OFS_LOL, page_ff) ? lol_ff :
                  reg_hit(reg_addr, `OFS_POWER, page_ff) ? power_ff :
                  reg_hit(reg_addr, `OFS_CDR, page_ff) ? cdr_ff :
                  reg_hit(reg_addr, `OFS_MASK_LOS, page_ff) ? mask_los_ff :
                  reg_hit(reg_addr, `OFS_MASK_FAULT, page_ff) ? mask_fault_ff :
                  reg_hit(reg_addr, `OFS_MASK_LOL, page_ff) ? mask_lol_ff :
                  reg_hit(reg_addr, `OFS_PAGE, page_ff) ? page_ff :
                  reg_hit(reg_addr, `OFS_EQ, page_ff) ? eq_ff[15:8] :
                  reg_hit(reg_addr, `OFS_EQ + 8'h01, page_ff) ? eq_ff[7:0] :
                  reg_hit(reg_addr, `OFS_EMPH, page_ff) ? emph_ff[15:8] :
                  reg_hit(reg_addr, `OFS_EMPH + 8'h01, page_ff) ? emph_ff[7:0] :
                  reg_hit(reg_addr, `OFS_AMP, page_ff) ? amp_ff[15:8] :
                  reg_hit(reg_addr, `OFS_AMP + 8'h01, page_ff) ? amp_ff[7:0] : 8'h00;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_tx_lol;
    (|tx_lol_s) && !clr_all |=> (lol_ff[7:4] & $past(tx_lol_s)) == $past(tx_lol_s);
  endproperty
  a_tx_lol: assert property (p_tx_lol) else $error("tx lock loss not latched");

  property p_rx_lol;
    (|rx_lol_s) && !clr_all |=> (lol_ff[3:0] & $past(rx_lol_s)) == $past(rx_lol_s);
  endproperty
  a_rx_lol: assert property (p_rx_lol) else $error("rx lock loss not latched");

  property p_lol_hold;
    lol_ff[0] && !rd_lol && !clr_all |=> lol_ff[0];
  endproperty
  a_lol_hold: assert property (p_lol_hold) else $error("lock loss dropped without read");

  property p_cdr_tx;
    wr_cdr && !clr_all |=> tx_retimer_on == $past(wr_data[7:4]);
  endproperty
  a_cdr_tx: assert property (p_cdr_tx) else $error("tx retimer control wrong");

  property p_cdr_rx;
    wr_cdr && !clr_all |=> rx_retimer_on == $past(wr_data[3:0]);
  endproperty
  a_cdr_rx: assert property (p_cdr_rx) else $error("rx retimer control wrong");

  property p_amp;
    rx_amp_code[15:12] <= 4'h3 && rx_amp_code[11:8] <= 4'h3 && rx_amp_code[7:4] <= 4'h3 && rx_amp_code[3:0] <= 4'h3;
  endproperty
  a_amp: assert property (p_amp) else $error("reserved amplitude code held");

  property p_eq;
    wr_stb && reg_addr == 8'hEA && page_ff == 8'h03 && wr_data[7:4] >= 4'hB && !clr_all |=> $stable(tx_eq_code[15:12]);
  endproperty
  a_eq: assert property (p_eq) else $error("reserved equalization code taken");

  property p_emph;
    wr_stb && reg_addr == 8'hEC && page_ff == 8'h03 && wr_data[3:0] <= 4'h7 && !clr_all
      |=> rx_emph_code[11:8] == $past(wr_data[3:0]);
  endproperty
  a_emph: assert property (p_emph) else $error("legal emphasis code lost");

  property p_reset_init;
    (!rst_n_s)[*5] |-> ##[0:1] core_reset;
  endproperty
  a_reset_init: assert property (p_reset_init) else $error("reset pin not honoured");

  property p_init;
    init_cnt_ff == 32'h00000001 && !clr_all |=> !data_not_ready;
  endproperty
  a_init: assert property (p_init) else $error("init did not complete");

  property p_ready_irq;
    $fell(data_not_ready) |=> !irq_out_n;
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("no interrupt on ready");

  property p_lp;
    lp_s && !clr_all |=> low_power_active;
  endproperty
  a_lp: assert property (p_lp) else $error("low power not entered");

  property p_los_irq;
    (|(rx_los_s & ~mask_los_ff[3:0])) && !clr_all && !wr_stb ##1 !clr_all |=> !irq_out_n;
  endproperty
  a_los_irq: assert property (p_los_irq) else $error("loss of signal missed");

  property p_fault_irq;
    (|(tx_fault_s & ~mask_fault_ff[3:0])) && !clr_all && !wr_stb ##1 !clr_all |=> !irq_out_n;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("tx fault missed");

  property p_irq_on;
    (|(lol_ff & ~mask_lol_ff)) |=> !irq_out_n;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt not asserted");

  property p_irq_off;
    !irq_cond |=> irq_out_n;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt not released");

  property p_mask;
    (&mask_lol_ff) && (&mask_los_ff[3:0]) && (&mask_fault_ff[3:0]) && !ready_flag_ff |=> irq_out_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked source raised interrupt");

  property p_deselect;
    sel_n_s |=> !sda_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("answered while deselected");

  property p_pdown;
    power_ff[`BIT_PDOWN] && !clr_all |=> low_power_active;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down ignored");

  c_read_lol: cover property (rd_lol && lol_ff != 8'h00);
  c_write_cdr: cover property (wr_cdr);
  c_ready: cover property ($fell(data_not_ready));
endmodule
`default_nettype wire

// ### dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host controller on the two-wire bus.
module host_model (
  // Clock.
  input wire logic clk_sys,
  // Bus lines.
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  int q = 5;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w;
    repeat (q) @(posedge clk_sys);
    #10;
  endtask
  task automatic bt(input logic b, output logic r);
    sda_low = !b;
    w;
    scl = 1'b1;
    w;
    r = sda_line;
    w;
    scl = 1'b0;
    w;
  endtask
  task automatic st;
    sda_low = 1'b0;
    w;
    scl = 1'b1;
    w;
    sda_low = 1'b1;
    w;
    scl = 1'b0;
    w;
  endtask
  task automatic sp;
    sda_low = 1'b1;
    w;
    scl = 1'b1;
    w;
    sda_low = 1'b0;
    w;
  endtask
  task automatic bx(input logic [7:0] t, input logic ai, output logic [7:0] r, output logic ao);
    for (int i = 7; i >= 0; i--) bt(t[i], r[i]);
    bt(ai, ao);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic [2:0] k;
    st;
    bx(8'hA0, 1'b1, x, k[0]);
    bx(a, 1'b1, x, k[1]);
    bx(d, 1'b1, x, k[2]);
    sp;
    ok = (k === 3'h0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic [3:0] k;
    st;
    bx(8'hA0, 1'b1, x, k[0]);
    bx(a, 1'b1, x, k[1]);
    st;
    bx(8'hA1, 1'b1, x, k[2]);
    bx(8'hFF, 1'b1, d, k[3]);
    sp;
    ok = (k[2:0] === 3'h0);
  endtask
endmodule
`default_nettype wire

// ### dv/transceiver_mgmt_ctrl_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_regs.svh"
module transceiver_mgmt_ctrl_status_bench;
  localparam int INIT = 50;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reset_in_n = 1'b1;
  logic module_select_n = 1'b0;
  logic low_power_request = 1'b0;
  logic [3:0] tx_lock_lost = 4'h0;
  logic [3:0] rx_lock_lost = 4'h0;
  logic [3:0] rx_signal_lost = 4'h0;
  logic [3:0] tx_fault = 4'h0;
  logic scl, sda_low, sda_out, sda_oe, irq_out_n, lpa, core_reset, dnr;
  logic [3:0] tx_on, rx_on;
  logic [15:0] eq, emph, amp;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  wire logic sda_w = !((sda_oe && !sda_out) || sda_low);
  always #50 clk_sys = !clk_sys;
  host_model u_host (.clk_sys(clk_sys), .sda_line(sda_w), .scl(scl), .sda_low(sda_low));
  transceiver_mgmt_ctrl_status #(.INIT_CYCLES(32'(INIT))) DUT (.clk_sys(clk_sys), .rst(rst),
    .reset_in_n(reset_in_n), .module_select_n(module_select_n), .low_power_request(low_power_request),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq_out_n(irq_out_n),
    .tx_lock_lost(tx_lock_lost), .rx_lock_lost(rx_lock_lost), .rx_signal_lost(rx_signal_lost),
    .tx_fault(tx_fault), .tx_retimer_on(tx_on), .rx_retimer_on(rx_on), .tx_eq_code(eq),
    .rx_emph_code(emph), .rx_amp_code(amp), .low_power_active(lpa), .core_reset(core_reset),
    .data_not_ready(dnr));
  // ==========================================
  // Shared tasks.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.wr(a, d, ok);
    chk({15'h0, ok}, 16'h1);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    chk({7'h0, ok, d}, {8'h01, e});
  endtask
  task automatic wirq(input logic v);
    for (int i = 0; i < 400 && irq_out_n !== v; i++) cyc(1);
    chk({15'h0, irq_out_n}, {15'h0, v});
  endtask
  task automatic ready_seq;
    cyc(INIT - 4);
    chk({15'h0, dnr}, 16'h1);
    cyc(8);
    chk({15'h0, dnr}, 16'h0);
    wirq(1'b0);
    rreg(`OFS_STATUS, 8'h00);
    wirq(1'b1);
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_init;
    chk({8'h0, tx_on, rx_on}, 16'h0);
    ready_seq;
    $display("init done");
  endtask
  task automatic t_cdr;
    logic ok;
    wreg(`OFS_CDR, 8'hA5);
    chk({8'h0, tx_on, rx_on}, 16'h00A5);
    rreg(`OFS_CDR, 8'hA5);
    module_select_n = 1'b1;
    cyc(20);
    u_host.wr(`OFS_CDR, 8'h3C, ok);
    chk({ok, 7'h0, tx_on, rx_on}, 16'h00A5);
    module_select_n = 1'b0;
    cyc(20);
    rreg(8'h10, 8'h00);
    $display("cdr done");
  endtask
  task automatic t_codes;
    logic [7:0] v1[3] = '{8'hA9, 8'h76, 8'h32};
    logic [7:0] v2[3] = '{8'h87, 8'h54, 8'h10};
    logic [7:0] rv[3] = '{8'hB0, 8'h82, 8'h41};
    logic [7:0] ex[3] = '{8'hA0, 8'h72, 8'h31};
    logic [7:0] o;
    u_host.q = 9;
    wreg(`OFS_PAGE, `UPPER_PAGE);
    for (int k = 0; k < 3; k++) begin
      o = `OFS_EQ + 8'(2 * k);
      wreg(o, v1[k]);
      wreg(o + 8'h01, v2[k]);
      chk(k == 0 ? eq : k == 1 ? emph : amp, {v1[k], v2[k]});
      wreg(o, rv[k]);
      chk(k == 0 ? eq : k == 1 ? emph : amp, {ex[k], v2[k]});
      rreg(o, ex[k]);
    end
    u_host.q = 5;
    $display("codes done");
  endtask
  task automatic t_flags;
    tx_lock_lost = 4'h1;
    rx_lock_lost = 4'h8;
    cyc(6);
    tx_lock_lost = 4'h0;
    rx_lock_lost = 4'h0;
    wirq(1'b0);
    rreg(`OFS_LOL, 8'h18);
    rreg(`OFS_LOL, 8'h00);
    wirq(1'b1);
    rx_signal_lost = 4'h2;
    wirq(1'b0);
    rx_signal_lost = 4'h0;
    rreg(`OFS_LOS, 8'h02);
    wirq(1'b1);
    tx_fault = 4'h4;
    wirq(1'b0);
    tx_fault = 4'h0;
    rreg(`OFS_FAULT, 8'h04);
    wirq(1'b1);
    $display("flags done");
  endtask
  task automatic t_mask;
    wreg(`OFS_MASK_LOL, 8'hFF);
    wreg(`OFS_MASK_FAULT, 8'h0F);
    wreg(`OFS_MASK_LOS, 8'h0F);
    rx_signal_lost = 4'h1;
    cyc(30);
    chk({15'h0, irq_out_n}, 16'h1);
    wreg(`OFS_MASK_LOS, 8'h00);
    wirq(1'b0);
    rx_signal_lost = 4'h0;
    rreg(`OFS_LOS, 8'h01);
    wirq(1'b1);
    $display("mask done");
  endtask
  task automatic t_power;
    low_power_request = 1'b1;
    cyc(6);
    chk({15'h0, lpa}, 16'h1);
    low_power_request = 1'b0;
    cyc(6);
    chk({15'h0, lpa}, 16'h0);
    wreg(`OFS_POWER, 8'h02);
    chk({15'h0, lpa}, 16'h1);
    wreg(`OFS_POWER, 8'h00);
    chk({15'h0, lpa}, 16'h0);
    $display("power done");
  endtask
  task automatic t_reset;
    wreg(`OFS_CDR, 8'hFF);
    reset_in_n = 1'b0;
    cyc(3);
    reset_in_n = 1'b1;
    cyc(12);
    chk({7'h0, core_reset, tx_on, rx_on}, 16'h00FF);
    reset_in_n = 1'b0;
    cyc(20);
    chk({7'h0, core_reset, tx_on, rx_on}, 16'h0100);
    reset_in_n = 1'b1;
    cyc(6);
    chk({14'h0, core_reset, dnr}, 16'h1);
    ready_seq;
    $display("reset done");
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Main sequence and hang limit.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    cyc(16);
    rst = 1'b0;
    t_init;
    t_cdr;
    t_codes;
    t_flags;
    t_mask;
    t_power;
    t_reset;
    test_done;
  end
endmodule
`default_nettype wire
